/* logic/ast_params.svh */
// Purpose: Register offsets, field positions, reset values and counts
// Assumes: 16-bit registers on one 32-bit Wishbone word each
// Notes: Functional notes list the behaviour the core keeps
//
// Functional notes
// - Format field picks 8N, 8E, 8O or 9N
// - Stop select gives one or two stops
// - Reset format is 8N with one stop
// - Enabled transmitter loads written word at once
// - Transmit queue four deep, full at bit 9
// - Write to full transmit queue is dropped
// - Reset empties both queues
// - Transmit event per load or on emptying
// - Break bit forces line low, no event
// - Receive event select: every, three, four
// - Reading receive port pops and updates errors
// - Receive queue four deep, empty read harmless
// - Overrun when full, halts until cleared
// - Any low stop bit flags framing error
// - Parity error flagged in parity modes only
// - Receiver idle low during a frame
// - Break loads zero word, waits line high
// - Address detect in 9N: only address words raise receive event
// - Loopback feeds transmitter into receiver
// - Bit rate is clock over 16 times divider+1
// - Disable empties queues, clears flags, break and transmit enable, keeps other config
// - Idle enabled line stays high
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH
`define AST_OFF_MODE 8'h00
`define AST_OFF_STAT 8'h04
`define AST_OFF_TX 8'h08
`define AST_OFF_RX 8'h0C
`define AST_OFF_DIV 8'h10
`define AST_MODE_EN 15
`define AST_MODE_LOOP 6
`define AST_MODE_FMT 1
`define AST_MODE_STOP 0
`define AST_ST_TXISEL 15
`define AST_ST_BRK 11
`define AST_ST_TXEN 10
`define AST_ST_RXISEL 6
`define AST_ST_ADDRESS_DETECT_ENABLE 5
`define AST_ST_OVERRUN_FLAG 1
`define AST_MODE_RST 16'h0000
`define AST_STAT_RST 16'h0000
`define AST_DIV_RST 16'h0000
`define AST_OVS_LAST 4'hF
`define AST_OVS_MID 4'h7
`define AST_FIFO_DEPTH 4
`endif

/* logic/ast_pkg.sv */
// Purpose: Types shared by the serial transceiver modules
// Assumes: Nothing beyond the parameter header
// Notes: Receive states follow a Gray path
package ast_pkg;
   typedef enum logic [1:0] {
      AST_FMT_8N = 2'b00,
      AST_FMT_8E = 2'b01,
      AST_FMT_8O = 2'b10,
      AST_FMT_9N = 2'b11
   } ast_fmt_t;
   typedef enum logic {
      AST_TX_IDLE = 1'b0,
      AST_TX_SHIFT = 1'b1
   } ast_tx_state_t;
   typedef enum logic [2:0] {
      AST_RX_IDLE = 3'b000,
      AST_RX_START = 3'b001,
      AST_RX_DATA = 3'b011,
      AST_RX_PUSH = 3'b010,
      AST_RX_HOLD = 3'b110,
      AST_RX_BREAK = 3'b111
   } ast_rx_state_t;
endpackage

/* logic/ast_fifo_if.sv */
// Purpose: Signals between the core and one of its queues
// Assumes: Count width fits the queue depth
// Notes: Push into a full queue is ignored by the queue
`timescale 1ns/10ps
interface ast_fifo_if #(parameter int W = 9, parameter int CW = 3);
   logic push;
   logic pop;
   logic flush;
   logic [W-1:0] wdata;
   logic [W-1:0] rdata;
   logic [CW-1:0] count;
   logic full;
   logic empty;
   modport src (output push, pop, flush, wdata, input rdata, count, full, empty);
   modport fifo (input push, pop, flush, wdata, output rdata, count, full, empty);
endinterface

/* logic/ast_fifo.sv */
// Purpose: Small first-in first-out queue for the transceiver
// Assumes: DEPTH below 2**CW
// Notes: Full push leaves stored entries untouched
`timescale 1ns/10ps
module ast_fifo #(
   parameter int W = 9,
   parameter int DEPTH = 4,
   parameter int CW = 3
) (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   ast_fifo_if.fifo f_if
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW-1:0] PLAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] CFULL = CW'(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   wire do_push = f_if.push & (count_reg != CFULL);
   wire do_pop = f_if.pop & (count_reg != '0);
   assign f_if.full = (count_reg == CFULL);
   assign f_if.empty = (count_reg == '0);
   assign f_if.count = count_reg;
   assign f_if.rdata = mem[rd_ptr_reg];
   always_ff @(posedge core_clk_in) begin
      if (do_push & ~f_if.flush) begin
         mem[wr_ptr_reg] <= f_if.wdata;
      end
   end
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else if (f_if.flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (do_push) wr_ptr_reg <= (wr_ptr_reg == PLAST) ? '0 : wr_ptr_reg + 1'b1;
         if (do_pop) rd_ptr_reg <= (rd_ptr_reg == PLAST) ? '0 : rd_ptr_reg + 1'b1;
         count_reg <= count_reg + CW'(do_push) - CW'(do_pop);
      end
   end
   chk_full_drop: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      f_if.full && f_if.push && !f_if.pop && !f_if.flush |=> f_if.full && $stable(wr_ptr_reg))
      else $error("push into full queue changed it");
endmodule

/* logic/ast_core.sv */
// Purpose: Asynchronous serial transceiver with Wishbone register access
// Assumes: Wishbone classic slave, 100 MHz core clock
// Notes: Transmit and receive event outputs are one-cycle pulses
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/10ps
`include "ast_params.svh"
module ast_core import ast_pkg::*; #(
   parameter int DEPTH = `AST_FIFO_DEPTH
) (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic serial_in_pin_in,
   output logic serial_out_pin_out,
   output logic transmit_irq_flag_out,
   output logic receive_irq_flag_out
);
   // ------------------------------------------------------------
   // Configuration and status registers
   // ------------------------------------------------------------
   logic module_enable_reg;
   logic loopback_enable_reg;
   ast_fmt_t frame_format_select_reg;
   logic stop_count_select_reg;
   logic transmit_irq_select_reg;
   logic break_send_control_reg;
   logic transmit_enable_reg;
   logic [1:0] receive_irq_select_reg;
   logic address_detect_enable_reg;
   logic overrun_flag_reg;
   logic [15:0] bit_rate_divider_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic [8:0] rx_last_reg;
   logic [15:0] div_cnt_reg;
   logic serial_out_reg;
   logic tx_irq_reg;
   logic rx_irq_reg;
   ast_fifo_if #(.W(9), .CW(3)) txf();
   ast_fifo_if #(.W(11), .CW(3)) rxf();
   localparam logic [2:0] CNT_FULL = 3'(DEPTH);
   localparam logic [2:0] CNT_THREE = 3'(DEPTH - 1);

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire acc = wb_cyc_in & wb_stb_in & ~ack_reg;
   wire wr = acc & wb_we_in;
   wire rd = acc & ~wb_we_in;
   wire sel_mode = (wb_adr_in == `AST_OFF_MODE);
   wire sel_stat = (wb_adr_in == `AST_OFF_STAT);
   wire sel_tx = (wb_adr_in == `AST_OFF_TX);
   wire sel_rx = (wb_adr_in == `AST_OFF_RX);
   wire sel_div = (wb_adr_in == `AST_OFF_DIV);
   wire [15:0] wmask = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
   wire [15:0] wd = wb_dat_in[15:0];
   wire en = module_enable_reg;
   wire nine = (frame_format_select_reg == AST_FMT_9N);
   wire par = (frame_format_select_reg == AST_FMT_8E) | (frame_format_select_reg == AST_FMT_8O);
   wire odd = (frame_format_select_reg == AST_FMT_8O);
   // Frame length counting start, data, parity and stop bits
   wire [3:0] frame_len = 4'd1 + ((nine | par) ? 4'd9 : 4'd8) + (stop_count_select_reg ? 4'd2 : 4'd1);
   wire [15:0] mode_v = {en, 8'h00, loopback_enable_reg, 3'b000,
      frame_format_select_reg, stop_count_select_reg};
   wire tx_full = txf.full;
   wire rx_da = ~rxf.empty;
   wire [10:0] rx_head = rxf.rdata;
   wire framing_error_flag_v = rx_da & rx_head[10];
   wire parity_error_flag_v = rx_da & rx_head[9];
   logic receiver_idle_flag;
   logic transmitter_empty_flag;
   wire [15:0] stat_v = {transmit_irq_select_reg, 3'b000, break_send_control_reg,
      transmit_enable_reg, tx_full, transmitter_empty_flag, receive_irq_select_reg,
      address_detect_enable_reg, receiver_idle_flag, parity_error_flag_v, framing_error_flag_v, overrun_flag_reg, rx_da};
   wire [15:0] mode_w = (mode_v & ~wmask) | (wd & wmask);
   wire [15:0] stat_w = (stat_v & ~wmask) | (wd & wmask);
   wire [15:0] div_w = (bit_rate_divider_reg & ~wmask) | (wd & wmask);
   wire rx_rd_pop = rd & sel_rx & rx_da;
   wire [8:0] rx_word = rx_da ? rx_head[8:0] : rx_last_reg;
   wire [15:0] rd_mux = sel_mode ? mode_v :
                        sel_stat ? stat_v :
                        sel_rx ? {7'h00, rx_word} :
                        sel_div ? bit_rate_divider_reg : 16'h0000;
   wire mode_wr = wr & sel_mode;
   wire stat_wr = wr & sel_stat;

   // ------------------------------------------------------------
   // Baud tick, sixteen per bit
   // ------------------------------------------------------------
   wire ovs_tick = en & (div_cnt_reg == bit_rate_divider_reg);
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         div_cnt_reg <= 16'h0000;
      end else if (!en | ovs_tick) begin
         div_cnt_reg <= 16'h0000;
      end else begin
         div_cnt_reg <= div_cnt_reg + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   logic rx_ovf_set;
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         module_enable_reg <= 1'b0;
         loopback_enable_reg <= 1'b0;
         frame_format_select_reg <= AST_FMT_8N;
         stop_count_select_reg <= 1'b0;
         transmit_irq_select_reg <= 1'b0;
         break_send_control_reg <= 1'b0;
         transmit_enable_reg <= 1'b0;
         receive_irq_select_reg <= 2'b00;
         address_detect_enable_reg <= 1'b0;
         overrun_flag_reg <= 1'b0;
         bit_rate_divider_reg <= `AST_DIV_RST;
      end else begin
         if (mode_wr) begin
            module_enable_reg <= mode_w[`AST_MODE_EN];
            loopback_enable_reg <= mode_w[`AST_MODE_LOOP];
            frame_format_select_reg <= ast_fmt_t'(mode_w[`AST_MODE_FMT +: 2]);
            stop_count_select_reg <= mode_w[`AST_MODE_STOP];
         end
         if (stat_wr) begin
            transmit_irq_select_reg <= stat_w[`AST_ST_TXISEL];
            receive_irq_select_reg <= stat_w[`AST_ST_RXISEL +: 2];
            address_detect_enable_reg <= stat_w[`AST_ST_ADDRESS_DETECT_ENABLE];
         end
         if (wr & sel_div) bit_rate_divider_reg <= div_w;
         if (!en) begin
            break_send_control_reg <= 1'b0;
            transmit_enable_reg <= 1'b0;
            overrun_flag_reg <= 1'b0;
         end else begin
            if (stat_wr) begin
               break_send_control_reg <= stat_w[`AST_ST_BRK];
               transmit_enable_reg <= stat_w[`AST_ST_TXEN];
            end
            // Overrun set beats a software clear in the same cycle
            if (rx_ovf_set) overrun_flag_reg <= 1'b1;
            else if (stat_wr & ~stat_w[`AST_ST_OVERRUN_FLAG]) overrun_flag_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Bus answer, one wait-free cycle after the strobe
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rx_last_reg <= 9'h000;
      end else begin
         ack_reg <= acc;
         if (rd) rdata_reg <= {16'h0000, rd_mux};
         if (rx_rd_pop) rx_last_reg <= rx_head[8:0];
      end
   end

   // ------------------------------------------------------------
   // Transmitter
   // ------------------------------------------------------------
   ast_tx_state_t tx_state_reg;
   logic [12:0] tx_frame_reg;
   logic [3:0] tx_left_reg;
   logic [3:0] tx_sub_reg;
   wire [8:0] tx_d = txf.rdata;
   wire tx_parity = (^tx_d[7:0]) ^ odd;
   wire [12:0] tx_frame_new = nine ? {3'b111, tx_d, 1'b0} :
      {3'b111, (par ? tx_parity : 1'b1), tx_d[7:0], 1'b0};
   wire tx_start = (tx_state_reg == AST_TX_IDLE) & en & transmit_enable_reg &
      ~txf.empty & ~break_send_control_reg;
   wire tx_bit_tick = ovs_tick & (tx_sub_reg == `AST_OVS_LAST);
   assign transmitter_empty_flag = txf.empty & (tx_state_reg == AST_TX_IDLE);
   assign txf.push = wr & sel_tx & wb_sel_in[0] & en;
   assign txf.wdata = wb_dat_in[8:0];
   assign txf.pop = tx_start;
   assign txf.flush = ~en;
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tx_state_reg <= AST_TX_IDLE;
         tx_frame_reg <= 13'h1FFF;
         tx_left_reg <= 4'h0;
         tx_sub_reg <= 4'h0;
      end else begin
         case (tx_state_reg)
            AST_TX_IDLE: begin
               tx_sub_reg <= 4'h0;
               if (tx_start) begin
                  tx_frame_reg <= tx_frame_new;
                  tx_left_reg <= frame_len;
                  tx_state_reg <= AST_TX_SHIFT;
               end
            end
            AST_TX_SHIFT: begin
               if (ovs_tick) tx_sub_reg <= tx_sub_reg + 4'h1;
               if (tx_bit_tick) begin
                  tx_frame_reg <= {1'b1, tx_frame_reg[12:1]};
                  tx_left_reg <= tx_left_reg - 4'h1;
                  if (tx_left_reg == 4'h1) tx_state_reg <= AST_TX_IDLE;
               end
               if (!en) tx_state_reg <= AST_TX_IDLE;
            end
            default: tx_state_reg <= AST_TX_IDLE;
         endcase
      end
   end
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         serial_out_reg <= 1'b1;
         tx_irq_reg <= 1'b0;
      end else begin
         serial_out_reg <= ~en | (~break_send_control_reg &
            ((tx_state_reg == AST_TX_IDLE) | tx_frame_reg[0]));
         // A push in the load cycle keeps the queue non-empty, so no event then
         tx_irq_reg <= tx_start & (~transmit_irq_select_reg |
            ((txf.count == 3'h1) & ~txf.push));
      end
   end

   // ------------------------------------------------------------
   // Receiver
   // ------------------------------------------------------------
   logic rx_s1_reg;
   logic rx_s2_reg;
   ast_rx_state_t rx_state_reg;
   logic [3:0] rx_sub_reg;
   logic [3:0] rx_left_reg;
   logic [10:0] rx_sh_reg;
   logic rx_framing_error_flag_reg;
   wire rx_line = loopback_enable_reg ? serial_out_reg : rx_s2_reg;
   wire [3:0] rx_n = frame_len - 4'd1;
   wire [10:0] rx_al = rx_sh_reg >> (4'd11 - rx_n);
   wire [8:0] rx_data = nine ? rx_al[8:0] : {1'b0, rx_al[7:0]};
   wire rx_parity_error_flag = par & ((^rx_al[7:0]) ^ rx_al[8] ^ odd);
   wire rx_samp = ovs_tick & (rx_sub_reg == `AST_OVS_LAST);
   wire rx_in_push = (rx_state_reg == AST_RX_PUSH) & ~rxf.full;
   wire rx_in_hold = (rx_state_reg == AST_RX_HOLD) & ~overrun_flag_reg & ~rxf.full;
   wire rx_push = rx_in_push | rx_in_hold;
   wire addr_mode = address_detect_enable_reg & nine;
   wire [2:0] rx_cnt_after = rxf.count + 3'h1 - {2'b00, rx_rd_pop};
   assign rx_ovf_set = (rx_state_reg == AST_RX_PUSH) & rxf.full;
   assign receiver_idle_flag = ~((rx_state_reg == AST_RX_START) | (rx_state_reg == AST_RX_DATA));
   assign rxf.push = rx_push & en;
   assign rxf.wdata = {rx_framing_error_flag_reg, rx_parity_error_flag, rx_data};
   assign rxf.pop = rx_rd_pop;
   assign rxf.flush = ~en;
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rx_s1_reg <= 1'b1;
         rx_s2_reg <= 1'b1;
      end else begin
         rx_s1_reg <= serial_in_pin_in;
         rx_s2_reg <= rx_s1_reg;
      end
   end
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rx_state_reg <= AST_RX_IDLE;
         rx_sub_reg <= 4'h0;
         rx_left_reg <= 4'h0;
         rx_sh_reg <= 11'h000;
         rx_framing_error_flag_reg <= 1'b0;
      end else if (!en) begin
         rx_state_reg <= AST_RX_IDLE;
         rx_sub_reg <= 4'h0;
      end else begin
         if (ovs_tick) rx_sub_reg <= rx_sub_reg + 4'h1;
         case (rx_state_reg)
            AST_RX_IDLE: begin
               rx_sub_reg <= 4'h0;
               rx_framing_error_flag_reg <= 1'b0;
               if (ovs_tick & ~rx_line) rx_state_reg <= AST_RX_START;
            end
            AST_RX_START: begin
               // Recheck at mid start bit to reject glitches
               if (ovs_tick & (rx_sub_reg == `AST_OVS_MID)) begin
                  rx_sub_reg <= 4'h0;
                  rx_left_reg <= rx_n;
                  rx_state_reg <= rx_line ? AST_RX_IDLE : AST_RX_DATA;
               end
            end
            AST_RX_DATA: begin
               if (rx_samp) begin
                  rx_sh_reg <= {rx_line, rx_sh_reg[10:1]};
                  rx_left_reg <= rx_left_reg - 4'h1;
                  if ((rx_left_reg <= (stop_count_select_reg ? 4'd2 : 4'd1)) & ~rx_line) begin
                     rx_framing_error_flag_reg <= 1'b1;
                  end
                  if (rx_left_reg == 4'h1) rx_state_reg <= AST_RX_PUSH;
               end
            end
            AST_RX_PUSH: begin
               if (rxf.full) rx_state_reg <= AST_RX_HOLD;
               else if (rx_framing_error_flag_reg & (rx_data == 9'h000)) rx_state_reg <= AST_RX_BREAK;
               else rx_state_reg <= AST_RX_IDLE;
            end
            AST_RX_HOLD: begin
               if (rx_in_hold) rx_state_reg <= AST_RX_IDLE;
            end
            AST_RX_BREAK: begin
               if (ovs_tick & rx_line) rx_state_reg <= AST_RX_IDLE;
            end
            default: rx_state_reg <= AST_RX_IDLE;
         endcase
      end
   end
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rx_irq_reg <= 1'b0;
      end else begin
         rx_irq_reg <= rxf.push & (addr_mode ? rx_data[8] :
            (~receive_irq_select_reg[1] |
            (receive_irq_select_reg[0] ? (rx_cnt_after == CNT_FULL) :
            (rx_cnt_after == CNT_THREE))));
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign wb_ack_out = ack_reg;
   assign wb_dat_out = rdata_reg;
   assign serial_out_pin_out = serial_out_reg;
   assign transmit_irq_flag_out = tx_irq_reg;
   assign receive_irq_flag_out = rx_irq_reg;

   // ------------------------------------------------------------
   // Queues and checks
   // ------------------------------------------------------------
   ast_fifo #(.W(9), .DEPTH(DEPTH), .CW(3)) u_txf (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .f_if(txf)
   );
   ast_fifo #(.W(11), .DEPTH(DEPTH), .CW(3)) u_rxf (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .f_if(rxf)
   );
   chk_break_low: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      en && break_send_control_reg |=> !serial_out_pin_out && !transmit_irq_flag_out)
      else $error("break did not force line low");
   chk_idle_high: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      en && !break_send_control_reg && tx_state_reg == AST_TX_IDLE |=> serial_out_pin_out)
      else $error("idle line not high");
   chk_tx_irq_mode: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      tx_start && transmit_irq_select_reg && txf.count > 3'h1 |=> !transmit_irq_flag_out)
      else $error("transmit event with queue not empty");
   chk_rx_irq_three: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      rxf.push && !addr_mode && receive_irq_select_reg == 2'b10 && rx_cnt_after == 3'h3
      |=> receive_irq_flag_out)
      else $error("missing receive event at three words");
   chk_overrun_set: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      en && rx_state_reg == AST_RX_PUSH && rxf.full |=> overrun_flag_reg && !rxf.push)
      else $error("overrun not flagged");
   chk_disable_flush: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      !en |=> rxf.empty && txf.empty && receiver_idle_flag && !transmit_enable_reg)
      else $error("disable did not reset queues");
   chk_frame_busy: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      rx_state_reg == AST_RX_DATA |-> !receiver_idle_flag)
      else $error("receiver idle during frame");
   chk_empty_read: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      rd && sel_rx && rxf.empty && !rxf.push |=> rxf.empty && rdata_reg[8:0] == $past(rx_last_reg))
      else $error("empty read disturbed queue");
   chk_tx_empty: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
      tx_state_reg == AST_TX_SHIFT |-> !transmitter_empty_flag)
      else $error("transmitter empty while shifting");
endmodule

/* dv/ast_remote.sv */
// Purpose: Remote serial device on the far side of the line
// Assumes: Fixed bit time in core clocks, caller enters at a clock edge
// Notes: Line idles high between frames
`timescale 1ns/10ps
module ast_remote #(parameter int BIT = 32) (
   input wire logic clk_in,
   input wire logic line_in,
   output logic line_out
);
   logic [10:0] got;
   initial begin
      line_out = 1'b1;
      got = 11'h000;
   end
   // Bits leave LSB first; the line is returned high after the frame
   task automatic send(input logic [10:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         line_out <= bits[i];
         repeat (BIT) @(posedge clk_in);
      end
      line_out <= 1'b1;
   endtask
   // Mid-bit sampling hides the one or two clocks of launch skew
   task automatic grab(input int n, output logic ok);
      int k;
      k = 0;
      while (line_in !== 1'b0 && k < 4000) begin
         @(posedge clk_in);
         k++;
      end
      ok = (k < 4000);
      repeat (BIT / 2) @(posedge clk_in);
      for (int i = 0; i < n; i++) begin
         got[i] = line_in;
         repeat (BIT) @(posedge clk_in);
      end
   endtask
endmodule

/* dv/async_serial_transceiver_bench.sv */
// Purpose: Self-checking bench for the serial transceiver
// Assumes: Divider 1, so one bit lasts 32 clocks
// Notes: Wishbone cycles are sampled at the rising edge
`timescale 1ns/10ps
module async_serial_transceiver_bench;
   logic clk, rstn, cyc, stb, we, ack, sin, sout, txi, rxi, ok;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat;
   int err_count, samples_checked, tx_n, rx_n;
   ast_core DUT (.core_clk_in(clk), .rstn_in(rstn), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .serial_in_pin_in(sin), .serial_out_pin_out(sout),
      .transmit_irq_flag_out(txi), .receive_irq_flag_out(rxi));
   ast_remote #(.BIT(32)) rem (.clk_in(clk), .line_in(sout), .line_out(sin));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (txi === 1'b1) tx_n++;
      if (rxi === 1'b1) rx_n++;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task summarize;
      $display("checks=%0d mismatches=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      int k;
      k = 0;
      @(posedge clk);
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'h3};
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      r = rdat;
      {cyc, stb, we} <= 3'b000;
      if (k >= 50) begin
         err_count++;
         summarize();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 32'h0000_0000, r);
      chk(r & m, e);
   endtask
   task t_cfg;
      rdchk(8'h00, 32'h0000_FFFF, 32'h0000_0000);
      rdchk(8'h10, 32'h0000_FFFF, 32'h0000_0000);
      wr(8'h10, 32'h0000_0001);
      rdchk(8'h10, 32'h0000_FFFF, 32'h0000_0001);
      wr(8'h00, 32'h0000_8000);
      rdchk(8'h04, 32'h0000_FFFF, 32'h0000_0110);
      $display("config test done");
   endtask
   task t_tx;
      wr(8'h04, 32'h0000_0400);
      wr(8'h08, 32'h0000_00A5);
      rem.grab(10, ok);
      chk(ok, 1'b1);
      if (!ok) summarize();
      chk(rem.got, 11'h34A);
      chk(sout, 1'b1);
      chk(tx_n, 1);
      rdchk(8'h04, 32'h0000_0100, 32'h0000_0100);
      $display("transmit test done");
   endtask
   task t_rx;
      rem.send(11'h278, 10);
      rdchk(8'h04, 32'h0000_0001, 32'h0000_0001);
      rdchk(8'h0C, 32'h0000_01FF, 32'h0000_003C);
      rdchk(8'h0C, 32'h0000_01FF, 32'h0000_003C);
      rdchk(8'h04, 32'h0000_0001, 32'h0000_0000);
      chk(rx_n, 1);
      rem.send(11'h0AA, 10);
      repeat (64) @(posedge clk);
      rdchk(8'h04, 32'h0000_0005, 32'h0000_0005);
      rdchk(8'h0C, 32'h0000_01FF, 32'h0000_0055);
      wr(8'h00, 32'h0000_8002);
      rem.send(11'h402, 11);
      rdchk(8'h04, 32'h0000_000D, 32'h0000_0009);
      rdchk(8'h0C, 32'h0000_01FF, 32'h0000_0001);
      chk(rx_n, 3);
      $display("receive test done");
   endtask
   task t_brk;
      wr(8'h04, 32'h0000_0C00);
      repeat (13 * 32) @(posedge clk);
      chk(sout, 1'b0);
      chk(tx_n, 1);
      wr(8'h04, 32'h0000_0400);
      repeat (64) @(posedge clk);
      chk(sout, 1'b1);
      $display("break test done");
   endtask
   // Loopback, 9-bit, two stops: five frames fill the receive side and overrun it
   task t_loop;
      wr(8'h00, 32'h0000_8047);
      wr(8'h04, 32'h0000_8480);
      for (int i = 1; i < 7; i++) wr(8'h08, {23'h00_0000, (i == 1 || i == 6), 8'(i)});
      rdchk(8'h04, 32'h0000_0200, 32'h0000_0200);
      repeat (2100) @(posedge clk);
      rdchk(8'h04, 32'h0000_0203, 32'h0000_0003);
      chk(tx_n, 32'h0000_0003);
      chk(rx_n, 32'h0000_0004);
      rdchk(8'h0C, 32'h0000_01FF, 32'h0000_0101);
      wr(8'h04, 32'h0000_8480);
      for (int i = 2; i < 6; i++) rdchk(8'h0C, 32'h0000_01FF, i);
      wr(8'h00, 32'h0000_0047);
      rdchk(8'h04, 32'h0000_FFFF, 32'h0000_8190);
      $display("loopback test done");
   endtask
   initial begin
      {rstn, cyc, stb, we, adr, wdat, sel} = 48'h0000_0000_0000;
      {err_count, samples_checked, tx_n, rx_n} = 128'h0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      t_cfg();
      t_tx();
      t_rx();
      t_brk();
      t_loop();
      summarize();
   end
endmodule
